// file: bench/ftc_chk.sv
`timescale 1ns/10ps
module ftc_chk #(
  parameter int NFAN = 3,
  parameter logic [23:0] BUS_TIMEOUT_CYCLES = 24'd20
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ftc_pkg::ftc_reg_req_t i_req,
  input wire logic i_global_lock,
  input wire logic i_standby_power,
  input wire logic [7:0] i_core_voltage_input,
  input wire logic [7:0] i_core_low_limit,
  input wire logic i_alert_enable,
  input wire logic [NFAN-1:0][7:0] i_max_duty,
  input wire logic i_bus_in_transaction,
  input wire logic i_bus_activity,
  input wire ftc_pkg::ftc_smooth_sleep_t o_smooth_sleep_cfg,
  input wire ftc_pkg::ftc_hyst_spin_to_t o_hyst_spin_to_cfg,
  input wire logic o_temp_limit_hyst_en,
  input wire logic o_core_low_status_set,
  input wire logic o_alert,
  input wire logic o_proc_hot_mon_en,
  input wire logic o_sleeping,
  input wire logic o_spinup_active,
  input wire logic [NFAN-1:0][7:0] o_fan_duty,
  input wire logic o_bus_release
);
  import ftc_pkg::*;
  logic [23:0] idle_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // counts idle transaction cycles; too long a wait for a repetition
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_bus_in_transaction || i_bus_activity ||
        o_hyst_spin_to_cfg.bus_timeout_control) begin
      idle_r <= '0;
    end else begin
      idle_r <= idle_r + 24'd1;
    end
  end
  a_release_count: assert property (
    (idle_r == BUS_TIMEOUT_CYCLES + 24'd1) == o_bus_release)
    else $error("bus release at wrong idle count");
  a_timeout_off: assert property (
    o_hyst_spin_to_cfg.bus_timeout_control [*2] |-> !o_bus_release)
    else $error("bus release while timeout disabled");
  a_lock_holds: assert property (
    i_req.wr_en && i_global_lock && $past(i_global_lock) &&
    i_req.addr == 8'h10 |-> ##2 $stable(o_smooth_sleep_cfg))
    else $error("locked register changed");
  a_force_unlocked: assert property (
    i_req.wr_en && i_req.addr == 8'h11 |-> ##2
    o_hyst_spin_to_cfg.force_full_speed == $past(i_req.wdata[1], 2))
    else $error("force bit not written");
  a_resv_zero: assert property (
    o_smooth_sleep_cfg.reserved == 3'h0)
    else $error("reserved bits stored");
  a_hyst_follow: assert property (
    $stable(o_hyst_spin_to_cfg.temp_limit_hysteresis_disable) |->
    o_temp_limit_hyst_en != o_hyst_spin_to_cfg.temp_limit_hysteresis_disable)
    else $error("hysteresis enable wrong");
  a_sleep_enter: assert property (
    o_smooth_sleep_cfg.core_voltage_sleep_gate && i_standby_power &&
    i_core_voltage_input < i_core_low_limit && !o_sleeping &&
    !o_spinup_active |=> o_core_low_status_set && o_sleeping &&
    o_alert == $past(i_alert_enable))
    else $error("sleep entry missing");
  a_mon_off: assert property (
    o_proc_hot_mon_en == !o_sleeping)
    else $error("monitoring not suspended");
  // spin-up flag and full duty follow the sleep flag's fall by one cycle
  a_spin_after: assert property (
    $fell(o_sleeping) |=> o_spinup_active && o_fan_duty == '1)
    else $error("no spin-up on recovery");
  a_force_duty: assert property (
    o_hyst_spin_to_cfg.force_full_speed && !o_sleeping &&
    !o_spinup_active && !$past(o_spinup_active) |->
    o_fan_duty == $past(i_max_duty))
    else $error("forced duty wrong");
endmodule
bind ftc_config_regs ftc_chk #(.NFAN(NFAN),
  .BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)) chk_u (.*);

// file: bench/ftc_host_model.sv
`timescale 1ns/10ps
module ftc_host_model (
  input wire logic i_clk,
  output ftc_pkg::ftc_reg_req_t o_req
);
  import ftc_pkg::*;
  initial o_req = '0;
  // one byte per call, with an idle cycle after it
  task automatic op(input logic w, input logic [7:0] a, d);
    @(posedge i_clk);
    o_req <= '{w, !w, a, (a == 8'h11) ? {3'h0, d[4:0]} : d};
    @(posedge i_clk);
    o_req <= '0;
  endtask
endmodule

// file: bench/test_fan_thermal_config_regs.sv
`timescale 1ns/10ps
module test_fan_thermal_config_regs;
  import ftc_pkg::*;
  localparam int TO = 20;
  logic clk = 0, rst = 1, lock = 0, stby = 0, aen = 0, fan_tachometer_input = 0;
  logic trans = 0, act = 0, rdv, hy, cls, alr, mon, slp, spn, rel;
  logic [7:0] vin = 8'h80, vlim = 8'h40, rdd;
  logic [15:0] b1 = 0, bl = 0, b2 = 0;
  logic [2:0][7:0] auto_d = 0, max_d = 0, duty;
  logic [23:0] spto = 24'd30;
  logic [18:0] t1, tl, t2;
  ftc_reg_req_t req;
  ftc_smooth_sleep_t c6;
  ftc_hyst_spin_to_t c7;
  logic [31:0] lf = 32'h5af6;
  logic [7:0] sh [2];
  logic [7:0] expq [$];
  int mismatches = 0, total_checks = 0, n;
  always #4 clk = ~clk;
  ftc_config_regs #(.BUS_TIMEOUT_CYCLES(24'(TO))) dut_u (
    .i_clk(clk), .i_rst(rst), .i_req(req), .i_global_lock(lock),
    .i_standby_power(stby), .i_core_voltage_input(vin),
    .i_core_low_limit(vlim), .i_alert_enable(aen),
    .i_smooth_base_r1(b1), .i_smooth_base_local(bl),
    .i_smooth_base_r2(b2), .i_auto_duty(auto_d), .i_max_duty(max_d),
    .i_fan_tachometer_input(fan_tachometer_input), .i_spinup_timeout(spto),
    .i_bus_in_transaction(trans), .i_bus_activity(act),
    .o_rd_data(rdd), .o_rd_valid(rdv), .o_smooth_sleep_cfg(c6),
    .o_hyst_spin_to_cfg(c7), .o_smooth_time_r1(t1),
    .o_smooth_time_local(tl), .o_smooth_time_r2(t2),
    .o_temp_limit_hyst_en(hy), .o_core_low_status_set(cls),
    .o_alert(alr), .o_proc_hot_mon_en(mon), .o_sleeping(slp),
    .o_spinup_active(spn), .o_fan_duty(duty), .o_bus_release(rel));
  ftc_host_model host_u (.i_clk(clk), .o_req(req));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [18:0] st(input logic [15:0] b,
                                     input logic s, x);
    logic [31:0] v;
    v = s ? {b, 2'b00} : b;
    if (x) v = (v * 357) >> 8;
    return v[18:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // shadow follows lock so reads expect the value kept under lock
  task automatic wr(input logic [7:0] a, d);
    host_u.op(1'b1, a, d);
    if (a == 8'h10 && !lock) sh[0] = d & 8'hc7;
    if (a == 8'h11) sh[1] = lock ? {sh[1][7:2], d[1], sh[1][0]} : d & 8'h1f;
  endtask
  task automatic rd(input logic [7:0] a);
    expq.push_back(a == 8'h10 ? sh[0] : a == 8'h11 ? sh[1] : 8'h00);
    host_u.op(1'b0, a, 8'h00);
  endtask
  always @(posedge clk)
    if (rdv) chk("rd_data", expq.pop_front(), rdd);
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial begin
    sh[0] = 0;
    sh[1] = 0;
    repeat (10) @(posedge clk);
    rst <= 0;
    rd(8'h10);
    rd(8'h11);
    rd(8'h20);
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      wr({7'h08, i[0]}, lf[7:0]);
      rd({7'h08, i[0]});
    end
    lock <= 1;
    wr(8'h10, ~sh[0]);
    wr(8'h11, ~sh[1]);
    rd(8'h10);
    rd(8'h11);
    lock <= 0;
    lf = nx(lf);
    b1 <= lf[15:0];
    bl <= lf[31:16];
    b2 <= 16'hffff;
    for (int i = 0; i < 16; i++) begin
      wr(8'h10, {i[3], 4'h0, i[2:0]});
      repeat (3) @(posedge clk);
      chk("t1", st(b1, i[0], i[3]), t1);
      chk("tl", st(bl, i[1], i[3]), tl);
      chk("t2", st(b2, i[2], i[3]), t2);
    end
    lf = nx(lf);
    max_d <= lf[23:0];
    auto_d <= ~lf[23:0];
    wr(8'h11, 8'h03);
    repeat (3) @(posedge clk);
    chk("hyst", 1'b0, hy);
    chk("duty", max_d, duty);
    wr(8'h11, 8'h00);
    repeat (3) @(posedge clk);
    chk("hyst", 1'b1, hy);
    chk("duty_auto", auto_d, duty);
    aen <= 1;
    stby <= 1;
    wr(8'h10, 8'h40);
    for (int m = 0; m < 2; m++) begin
      wr(8'h11, {4'h0, m[0], 3'h0});
      vin <= 8'h3f;
      repeat (4) @(posedge clk);
      chk("sleep", 3'b101, {slp, mon, alr});
      vin <= 8'h40;
      n = 0;
      // fan_tachometer_input pulses every other cycle must not cut method one short
      repeat (60) begin
        @(posedge clk);
        fan_tachometer_input <= !fan_tachometer_input;
        if (spn) n++;
      end
      fan_tachometer_input <= 0;
      chk("spin_long", 32'(m), n >= 30);
      chk("mon_back", 1'b1, mon);
    end
    stby <= 0;
    trans <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!rel && n < 100);
    chk("release_at", TO + 2, n);
    trans <= 0;
    wr(8'h11, 8'h10);
    trans <= 1;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (rel) n++;
    end
    chk("release_off", 0, n);
    trans <= 0;
    // second reset after writes, so the zero reads mean something
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    sh[0] = 0;
    sh[1] = 0;
    rd(8'h10);
    rd(8'h11);
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule

// file: hw/ftc_config_regs.sv
// Contract
// [R1] smoothing bit 0 set: remote-one channel smoothing time times four.
// [R2] smoothing bit 1 set: local channel smoothing time times four.
// [R3] smoothing bit 2 set: remote-two channel smoothing time times four.
// [R4] extra stretch bit set: every smoothing time grows a further 39.2%.
// [R5] gating, standby, core low: set status bit, alert if enabled.
// [R6] gated core-low suspends processor-hot monitoring until voltage recovers.
// [R7] on recovery run a fan spin-up, then restore programmed fan state.
// [R8] hysteresis applies on temp-limit output unless disable bit set.
// [R9] force-full-speed bit drives every fan at its maximum duty.
// [R10] force-full-speed bit stays writable even under the global lock.
// [R11] spin-up method bit set: two fan_tachometer_input pulses do not end spin-up.
// [R12] spin-up method bit set: pwm high for whole spin-up timeout.
// [R13] bus-timeout bit controls the timeout; writing one disables it.
// [R14] active timeout: idle over 35 ms mid-transaction releases the bus.
// [R15] global lock makes both registers read-only except force-full-speed.
// [R16] power-display flag is plain lockable storage for firmware.
// [R17] host never writes reserved bits 7:5 of the second register.
// [R18] both registers clear to zero at power-on.
// [R19] reserved bits 5:3 of first register read zero, ignore writes.
`timescale 1ns/10ps
`include "ftc_regs.svh"

module ftc_config_regs #(
  parameter int NFAN = 3,
  parameter int SW = 16,
  parameter int TW = 24,
  parameter logic [23:0] BUS_TIMEOUT_CYCLES =
    24'(`FTC_CLK_HZ / `FTC_MS_PER_S * `FTC_BUS_TIMEOUT_MS)
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ftc_pkg::ftc_reg_req_t i_req,
  input wire logic i_global_lock,
  input wire logic i_standby_power,
  input wire logic [7:0] i_core_voltage_input,
  input wire logic [7:0] i_core_low_limit,
  input wire logic i_alert_enable,
  input wire logic [SW-1:0] i_smooth_base_r1,
  input wire logic [SW-1:0] i_smooth_base_local,
  input wire logic [SW-1:0] i_smooth_base_r2,
  input wire logic [NFAN-1:0][7:0] i_auto_duty,
  input wire logic [NFAN-1:0][7:0] i_max_duty,
  input wire logic i_fan_tachometer_input,
  input wire logic [TW-1:0] i_spinup_timeout,
  input wire logic i_bus_in_transaction,
  input wire logic i_bus_activity,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output ftc_pkg::ftc_smooth_sleep_t o_smooth_sleep_cfg,
  output ftc_pkg::ftc_hyst_spin_to_t o_hyst_spin_to_cfg,
  output logic [SW+2:0] o_smooth_time_r1,
  output logic [SW+2:0] o_smooth_time_local,
  output logic [SW+2:0] o_smooth_time_r2,
  output logic o_temp_limit_hyst_en,
  output logic o_core_low_status_set,
  output logic o_alert,
  output logic o_proc_hot_mon_en,
  output logic o_sleeping,
  output logic o_spinup_active,
  output logic [NFAN-1:0][7:0] o_fan_duty,
  output logic o_bus_release
);
  import ftc_pkg::*;

  ftc_smooth_sleep_t cfg6_r;
  ftc_hyst_spin_to_t cfg7_r;
  ftc_state_t state_r;
  ftc_state_t state_nxt;
  logic core_low;
  logic gated_low;
  logic spin_start;
  logic spin_busy;
  logic wr6;
  logic wr7;
  logic timeout_active;
  logic [23:0] idle_cnt_r;
  logic released_r;

  assign wr6 = i_req.wr_en && i_req.addr == `FTC_ADDR_SMOOTH_SLEEP;
  assign wr7 = i_req.wr_en && i_req.addr == `FTC_ADDR_HYST_SPIN_TO;

  // register writes; reserved bits never store
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg6_r <= ftc_smooth_sleep_t'(`FTC_SMOOTH_SLEEP_RST); // see [R18]
    end else if (wr6 && !i_global_lock) begin // see [R15]
      cfg6_r <= ftc_smooth_sleep_t'(i_req.wdata &
                                    `FTC_SMOOTH_SLEEP_WMASK); // see [R19]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg7_r <= ftc_hyst_spin_to_t'(`FTC_HYST_SPIN_TO_RST); // see [R18]
    end else if (wr7 && !i_global_lock) begin
      // plain storage, lockable like the rest; see [R16]
      cfg7_r <= ftc_hyst_spin_to_t'(i_req.wdata &
                                    `FTC_HYST_SPIN_TO_WMASK); // see [R17]
    end else if (wr7) begin
      // under lock only the override bit moves; see [R10] [R15]
      cfg7_r <= ftc_hyst_spin_to_t'(
        (cfg7_r & ~`FTC_HYST_SPIN_TO_UNLOCKED) |
        (i_req.wdata & `FTC_HYST_SPIN_TO_UNLOCKED));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_req.rd_en;
    end
  end

  // data holds until the next read so a slow engine can still take it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= `FTC_RD_UNMAPPED;
    end else if (!i_req.rd_en) begin
      o_rd_data <= o_rd_data;
    end else if (i_req.addr == `FTC_ADDR_SMOOTH_SLEEP) begin
      o_rd_data <= cfg6_r; // see [R19]
    end else if (i_req.addr == `FTC_ADDR_HYST_SPIN_TO) begin
      o_rd_data <= cfg7_r;
    end else begin
      o_rd_data <= `FTC_RD_UNMAPPED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_smooth_sleep_cfg <= ftc_smooth_sleep_t'(`FTC_SMOOTH_SLEEP_RST);
    end else begin
      o_smooth_sleep_cfg <= cfg6_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hyst_spin_to_cfg <= ftc_hyst_spin_to_t'(`FTC_HYST_SPIN_TO_RST);
    end else begin
      o_hyst_spin_to_cfg <= cfg7_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_temp_limit_hyst_en <= 1'b1;
    end else begin
      o_temp_limit_hyst_en <=
        !cfg7_r.temp_limit_hysteresis_disable; // see [R8]
    end
  end

  // smoothing stretch per channel
  ftc_smooth_scale #(.W(SW)) u_scale_r1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_base(i_smooth_base_r1),
    .i_slow(cfg6_r.slow_remote1), // see [R1]
    .i_extra(cfg6_r.extra_smoothing_stretch), // see [R4]
    .o_time(o_smooth_time_r1)
  );

  ftc_smooth_scale #(.W(SW)) u_scale_local (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_base(i_smooth_base_local),
    .i_slow(cfg6_r.slow_local), // see [R2]
    .i_extra(cfg6_r.extra_smoothing_stretch), // see [R4]
    .o_time(o_smooth_time_local)
  );

  ftc_smooth_scale #(.W(SW)) u_scale_r2 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_base(i_smooth_base_r2),
    .i_slow(cfg6_r.slow_remote2), // see [R3]
    .i_extra(cfg6_r.extra_smoothing_stretch), // see [R4]
    .o_time(o_smooth_time_r2)
  );

  // core-voltage sleep gating
  assign core_low = i_core_voltage_input < i_core_low_limit;
  assign gated_low = cfg6_r.core_voltage_sleep_gate && i_standby_power &&
                     core_low; // see [R5]
  // start in the same cycle the state leaves sleep so busy is seen at once
  assign spin_start = state_r == FTC_ST_SLEEP && !core_low; // see [R7]

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FTC_ST_RUN: begin
        if (gated_low) begin
          state_nxt = FTC_ST_SLEEP;
        end
      end
      FTC_ST_SLEEP: begin
        if (!core_low) begin
          state_nxt = FTC_ST_SPIN; // see [R6]
        end
      end
      FTC_ST_SPIN: begin
        if (!spin_busy) begin
          state_nxt = FTC_ST_RUN; // see [R7]
        end
      end
      default: begin
        state_nxt = FTC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= FTC_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one pulse per entry; the status bit itself lives outside
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_core_low_status_set <= 1'b0;
    end else begin
      o_core_low_status_set <= state_r == FTC_ST_RUN && gated_low; // see [R5]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alert <= 1'b0;
    end else begin
      o_alert <= state_nxt == FTC_ST_SLEEP && i_alert_enable; // see [R5]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_proc_hot_mon_en <= 1'b1;
    end else begin
      o_proc_hot_mon_en <= state_nxt != FTC_ST_SLEEP; // see [R6]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sleeping <= 1'b0;
    end else begin
      o_sleeping <= state_nxt == FTC_ST_SLEEP;
    end
  end

  ftc_spinup #(.TW(TW)) u_spinup (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(spin_start),
    .i_method(cfg7_r.spinup_method_select), // see [R11] [R12]
    .i_fan_tachometer_input_pulse(i_fan_tachometer_input),
    .i_timeout(i_spinup_timeout),
    .o_busy(spin_busy)
  );

  // lags the engine by one cycle, in step with the duty it forces
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_spinup_active <= 1'b0;
    end else begin
      o_spinup_active <= spin_busy;
    end
  end

  // fan duty: spin-up full on, then override, then automatic
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fan_duty <= '0;
    end else begin
      for (int i = 0; i < NFAN; i++) begin
        if (spin_busy) begin
          o_fan_duty[i] <= `FTC_DUTY_FULL; // see [R12]
        end else if (cfg7_r.force_full_speed) begin
          o_fan_duty[i] <= i_max_duty[i]; // see [R9]
        end else begin
          o_fan_duty[i] <= i_auto_duty[i];
        end
      end
    end
  end

  // bit one means timeout off; see [R13]
  assign timeout_active = !cfg7_r.bus_timeout_control;

  // one release per stall; the count restarts on any bus activity
  always_ff @(posedge i_clk) begin
    if (i_rst || !timeout_active || !i_bus_in_transaction ||
        i_bus_activity) begin
      idle_cnt_r <= '0;
      released_r <= 1'b0;
      o_bus_release <= 1'b0;
    end else if (!released_r && idle_cnt_r >= BUS_TIMEOUT_CYCLES) begin
      released_r <= 1'b1;
      o_bus_release <= 1'b1; // see [R14]
    end else begin
      o_bus_release <= 1'b0;
      if (!released_r) begin
        idle_cnt_r <= idle_cnt_r + 24'h000001;
      end
    end
  end

endmodule

// file: hw/ftc_pkg.sv
package ftc_pkg;

  typedef struct packed {
    logic extra_smoothing_stretch;
    logic core_voltage_sleep_gate;
    logic [2:0] reserved;
    logic slow_remote2;
    logic slow_local;
    logic slow_remote1;
  } ftc_smooth_sleep_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic bus_timeout_control;
    logic spinup_method_select;
    logic power_display_flag;
    logic force_full_speed;
    logic temp_limit_hysteresis_disable;
  } ftc_hyst_spin_to_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ftc_reg_req_t;

  // one bit changes along run -> sleep -> spin; spin -> run changes both bits
  typedef enum logic [1:0] {
    FTC_ST_RUN = 2'b00,
    FTC_ST_SLEEP = 2'b01,
    FTC_ST_SPIN = 2'b11
  } ftc_state_t;

endpackage

// file: hw/ftc_regs.svh
`ifndef FTC_REGS_SVH
`define FTC_REGS_SVH

// register offsets
`define FTC_ADDR_SMOOTH_SLEEP 8'h10
`define FTC_ADDR_HYST_SPIN_TO 8'h11

// power-on values
`define FTC_SMOOTH_SLEEP_RST 8'h00
`define FTC_HYST_SPIN_TO_RST 8'h00
`define FTC_RD_UNMAPPED 8'h00

// bits that stay writable while the global lock is set
`define FTC_HYST_SPIN_TO_UNLOCKED 8'h02

// reserved bits of both registers read as zero
`define FTC_SMOOTH_SLEEP_WMASK 8'hc7
`define FTC_HYST_SPIN_TO_WMASK 8'h1f

// smoothing stretch: x4 is a shift by two, +39.2% is 357/256
`define FTC_SLOW_SHIFT 2
`define FTC_EXTRA_NUM 9'h165
`define FTC_EXTRA_SHIFT 8

// spin-up ends early on this many fan_tachometer_input pulses
`define FTC_SPIN_FAN_TACHOMETER_INPUT_PULSES 2'h2

// time base
`define FTC_CLK_HZ 125000000
`define FTC_BUS_TIMEOUT_MS 35
`define FTC_MS_PER_S 1000

// full-on duty during spin-up
`define FTC_DUTY_FULL 8'hff

`endif

// file: hw/ftc_smooth_scale.sv
`timescale 1ns/10ps
`include "ftc_regs.svh"

module ftc_smooth_scale #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_base,
  input wire logic i_slow,
  input wire logic i_extra,
  output logic [W+2:0] o_time
);
  import ftc_pkg::*;

  logic [W+1:0] t4;
  logic [W+10:0] prod;
  logic [W+2:0] time_nxt;

  always_comb begin
    t4 = i_slow ? ({2'b00, i_base} << `FTC_SLOW_SHIFT) : {2'b00, i_base};
    prod = {9'h000, t4} * {{(W+2){1'b0}}, `FTC_EXTRA_NUM};
    if (i_extra) begin
      // 357/256 is within 0.2% of 1.392; cheaper than a divider
      time_nxt = prod[W+2+`FTC_EXTRA_SHIFT:`FTC_EXTRA_SHIFT];
    end else begin
      time_nxt = {1'b0, t4};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_time <= '0;
    end else begin
      o_time <= time_nxt;
    end
  end

endmodule

// file: hw/ftc_spinup.sv
`timescale 1ns/10ps
`include "ftc_regs.svh"

module ftc_spinup #(
  parameter int TW = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_method,
  input wire logic i_fan_tachometer_input_pulse,
  input wire logic [TW-1:0] i_timeout,
  output logic o_busy
);
  import ftc_pkg::*;

  logic [TW-1:0] cnt_r;
  logic [1:0] fan_tachometer_input_r;
  logic done;

  // method 1: fan_tachometer_input ignored, full timeout always runs
  always_comb begin
    done = (cnt_r + 1'b1 >= i_timeout) ||
           (!i_method && fan_tachometer_input_r >= `FTC_SPIN_FAN_TACHOMETER_INPUT_PULSES);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else if (i_start) begin
      o_busy <= 1'b1;
    end else if (o_busy && done) begin
      o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_start) begin
      cnt_r <= '0;
    end else if (o_busy) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_start) begin
      fan_tachometer_input_r <= 2'h0;
    end else if (o_busy && i_fan_tachometer_input_pulse &&
                 fan_tachometer_input_r < `FTC_SPIN_FAN_TACHOMETER_INPUT_PULSES) begin
      fan_tachometer_input_r <= fan_tachometer_input_r + 2'h1;
    end
  end

endmodule
